// ---- hw/rci_regs.vh ----
// constants for the reset cause and interrupt unit
// Functional notes
// RULE1: power-on clears flag; other resets leave it
// RULE2: crystal start-up 72 ms plus 1024 periods
// RULE3: time-out/power-down flags follow reset cause
// RULE4: resets load 000h; irq wake vectors 0004h
// RULE5: converter wake sets done, clears running
// RULE6: four sources: timer, pin, port, converter
// RULE7: flags set regardless of any enable
// RULE8: global enable gates; vector at once (code vectors after the RULE15 latency)
// RULE9: any reset clears global enable
// RULE10: return-from-interrupt sets global enable
// RULE11: taking irq clears enable, pushes, vectors
// RULE12: software clears flag before re-enabling
// RULE13: converter flag/enable plus peripheral gate
// RULE14: pin, port, timer flags in control reg
// RULE15: latency three or four instruction cycles
// RULE16: sleep clears power-down, sets time-out
// RULE17: timer overflow flag bit 2, enable 5
// RULE18: pin edge per select; flag bit 1
// RULE19: write zero clears; event beats clear
`ifndef RCI_REGS_VH
`define RCI_REGS_VH
// register offsets
`define RCI_A_STATUS 8'h03
`define RCI_A_INTERRUPT_CONTROL 8'h0b
`define RCI_A_PIR 8'h0c
`define RCI_A_CONV 8'h1f
`define RCI_A_OPTION 8'h81
`define RCI_A_PIE 8'h8c
`define RCI_A_POWER_CONTROL_STATUS 8'h8e
`define RCI_A_EVSTS 8'h90
`define RCI_A_EVMSK 8'h91
// field positions
`define RCI_B_POR 1
`define RCI_B_PD 3
`define RCI_B_TO 4
`define RCI_B_GIE 7
`define RCI_B_PEIE 6
`define RCI_B_TIMER_OVERFLOW_ENABLE 5
`define RCI_B_INTE 4
`define RCI_B_GPIE 3
`define RCI_B_TIMER_OVERFLOW_FLAG 2
`define RCI_B_EXTERNAL_IRQ_FLAG 1
`define RCI_B_PORT_CHANGE_FLAG 0
`define RCI_B_CONVERTER_DONE_FLAG 6
`define RCI_B_CRUN 3
`define RCI_B_EDGE 6
// reset values
`define RCI_RST_OPTION 8'hff
`define RCI_RST_EVSTS 4'h1
// program counter targets
`define RCI_PC_RESET 13'h0000
`define RCI_PC_VECTOR 13'h0004
// oscillator modes
`define RCI_M_LP 3'h0
`define RCI_M_XT 3'h1
`define RCI_M_HS 3'h2
`define RCI_M_INTERNAL_RC_MODE 3'h4
`define RCI_M_EXTERNAL_RC_MODE 3'h6
// timing
`define RCI_PWRT_MS 72
`define RCI_CLK_KHZ 40000
`define RCI_OST_TOSC 1024
`define RCI_IRQ_LAT 2'h3
`endif

// ---- hw/rci_top.v ----
// reset cause recording, start-up delays and vectored interrupt logic
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
`include "rci_regs.vh"
module rci_top #(
   parameter CNT_W = 22,
   parameter PWRT_CYC = `RCI_PWRT_MS * `RCI_CLK_KHZ,
   parameter OST_CYC = `RCI_OST_TOSC
) (
   input wire core_clk_i,
   input wire rstn_i,
   input wire external_reset_pin_n_i,
   input wire external_irq_pin_i,
   input wire power_up_timer_enable_n_i,
   input wire [2:0] osc_mode_i,
   input wire wdt_timeout_i,
   input wire sleep_exec_i,
   input wire return_from_interrupt_i,
   input wire timer_overflow_i,
   input wire port_change_i,
   input wire conv_done_i,
   input wire [7:0] addr_i,
   input wire [7:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [7:0] rdata_o,
   output reg pc_load_o,
   output reg [12:0] pc_value_o,
   output reg stack_push_o,
   output reg resume_o,
   output reg core_hold_o,
   output reg irq_o
);

   // one-hot sequencer states
   localparam ST_POR = 7'h01;
   localparam ST_PWRT = 7'h02;
   localparam ST_OST = 7'h04;
   localparam ST_HOLD = 7'h08;
   localparam ST_RUN = 7'h10;
   localparam ST_SLEEP = 7'h20;
   localparam ST_WAKE = 7'h40;

   // loads are cut to the counter width on purpose
   localparam integer PWRT_M1 = PWRT_CYC - 1;
   localparam integer OST_M1 = OST_CYC - 1;
   localparam [CNT_W-1:0] PWRT_LD = PWRT_M1[CNT_W-1:0];
   localparam [CNT_W-1:0] OST_LD = OST_M1[CNT_W-1:0];

   // crystal families need the oscillator start-up wait
   function is_xtal;
      input [2:0] m;
      begin
         is_xtal = (m == `RCI_M_LP) | (m == `RCI_M_XT) | (m == `RCI_M_HS);
      end
   endfunction

   reg [6:0] state_r;
   reg [CNT_W-1:0] cnt_r;
   reg from_wake_r;
   reg wake_irq_r;
   reg [1:0] q_r;
   reg [1:0] lat_r;
   reg lat_act_r;
   // pin synchronisers
   reg external_reset_pin_s1_r;
   reg external_reset_pin_s2_r;
   reg ext_s1_r;
   reg ext_s2_r;
   reg ext_d_r;
   // fills with ones once the pin samples have reached the edge flop
   reg [2:0] ext_arm_r;
   // software visible state
   reg por_flag_r;
   reg to_r;
   reg pd_r;
   reg [7:0] interrupt_control_r;
   reg converter_done_flag_r;
   reg adie_r;
   reg [7:0] conv_r;
   reg [7:0] opt_r;
   reg [3:0] evs_r;
   reg [3:0] evm_r;

   // two flops before any logic sees a pin
   always @(posedge core_clk_i) begin
      if (!rstn_i) begin
         external_reset_pin_s1_r <= 1'b0;
         external_reset_pin_s2_r <= 1'b0;
         ext_s1_r <= 1'b0;
         ext_s2_r <= 1'b0;
         ext_d_r <= 1'b0;
         ext_arm_r <= 3'h0;
      end else begin
         external_reset_pin_s1_r <= external_reset_pin_n_i;
         external_reset_pin_s2_r <= external_reset_pin_s1_r;
         ext_s1_r <= external_irq_pin_i;
         ext_s2_r <= ext_s1_r;
         ext_d_r <= ext_s2_r;
         ext_arm_r <= {ext_arm_r[1:0], 1'b1};
      end
   end

   // edge select picks rising or falling edge
   wire ext_raw = opt_r[`RCI_B_EDGE] ? (ext_s2_r & ~ext_d_r)
                                     : (~ext_s2_r & ext_d_r); // [RULE18]
   // the flops reset low, so an idle-high pin would fake a rising edge
   // right after reset; edges count only once both flops hold pin samples
   wire ext_edge = ext_raw & ext_arm_r[2]; // [RULE18]

   wire wr_ic = wr_i & (addr_i == `RCI_A_INTERRUPT_CONTROL);
   wire wr_pir = wr_i & (addr_i == `RCI_A_PIR);
   wire wr_evs = wr_i & (addr_i == `RCI_A_EVSTS);

   // flags: event wins over a clearing write
   wire [2:0] ic_ev = {timer_overflow_i, ext_edge, port_change_i}; // [RULE6] [RULE7]
   wire [2:0] ic_fl_nxt = ic_ev | (wr_ic ? wdata_i[2:0] : interrupt_control_r[2:0]); // [RULE19]
   wire converter_done_flag_nxt = conv_done_i | (wr_pir ? wdata_i[`RCI_B_CONVERTER_DONE_FLAG] : converter_done_flag_r); // [RULE19]
   wire [7:0] ic_nxt = {wr_ic ? wdata_i[7:3] : interrupt_control_r[7:3], ic_fl_nxt}; // [RULE14]

   // any enabled request, global enable not yet applied
   wire irq_any = (ic_nxt[`RCI_B_TIMER_OVERFLOW_FLAG] & ic_nxt[`RCI_B_TIMER_OVERFLOW_ENABLE])
                | (ic_nxt[`RCI_B_EXTERNAL_IRQ_FLAG] & ic_nxt[`RCI_B_INTE])
                | (ic_nxt[`RCI_B_PORT_CHANGE_FLAG] & ic_nxt[`RCI_B_GPIE])
                | (ic_nxt[`RCI_B_PEIE] & converter_done_flag_nxt & adie_r); // [RULE13]
   wire global_irq_enable = ic_nxt[`RCI_B_GIE];
   wire bnd = (q_r == 2'h3);

   // reset-cause and wake events for the sticky status
   wire in_run = (state_r == ST_RUN);
   wire in_slp = (state_r == ST_SLEEP);
   wire ev_ext = ~external_reset_pin_s2_r & (in_run | in_slp);
   wire ev_wdt = wdt_timeout_i & in_run & ~ev_ext;
   wire ev_wake = (state_r == ST_WAKE);
   wire soft_rst = ev_ext | ev_wdt;
   wire [3:0] evs_set = {ev_wake, ev_wdt, ev_ext, 1'b0};
   wire [3:0] evs_clr = wr_evs ? wdata_i[3:0] : 4'h0;

   // main sequencer and registers
   always @(posedge core_clk_i) begin
      if (!rstn_i) begin
         state_r <= ST_POR;
         cnt_r <= {CNT_W{1'b0}};
         from_wake_r <= 1'b0;
         wake_irq_r <= 1'b0;
         q_r <= 2'h0;
         lat_r <= 2'h0;
         lat_act_r <= 1'b0;
         por_flag_r <= 1'b0; // [RULE1]
         to_r <= 1'b1; // [RULE3]
         pd_r <= 1'b1; // [RULE3]
         interrupt_control_r <= 8'h00; // [RULE9]
         converter_done_flag_r <= 1'b0;
         adie_r <= 1'b0;
         conv_r <= 8'h00;
         opt_r <= `RCI_RST_OPTION;
         evs_r <= `RCI_RST_EVSTS;
         evm_r <= 4'h0;
         pc_load_o <= 1'b0;
         pc_value_o <= `RCI_PC_RESET;
         stack_push_o <= 1'b0;
         resume_o <= 1'b0;
         core_hold_o <= 1'b1;
         irq_o <= 1'b0;
      end else begin
         pc_load_o <= 1'b0;
         stack_push_o <= 1'b0;
         resume_o <= 1'b0;
         q_r <= q_r + 2'h1;
         irq_o <= |(evs_r & evm_r);
         evs_r <= evs_set | (evs_r & ~evs_clr);
         interrupt_control_r <= ic_nxt;
         converter_done_flag_r <= converter_done_flag_nxt;
         // plain register writes
         if (wr_i) begin
            case (addr_i)
               `RCI_A_POWER_CONTROL_STATUS: por_flag_r <= wdata_i[`RCI_B_POR];
               `RCI_A_PIE: adie_r <= wdata_i[`RCI_B_CONVERTER_DONE_FLAG];
               `RCI_A_CONV: conv_r <= wdata_i;
               `RCI_A_OPTION: opt_r <= wdata_i;
               `RCI_A_EVMSK: evm_r <= wdata_i[3:0];
               default: ;
            endcase
         end
         case (state_r)
            ST_POR: begin
               core_hold_o <= 1'b1;
               from_wake_r <= 1'b0;
               // timer enable is active low
               if (!power_up_timer_enable_n_i) begin
                  cnt_r <= PWRT_LD;
                  state_r <= ST_PWRT; // [RULE2]
               end else if (is_xtal(osc_mode_i)) begin
                  cnt_r <= OST_LD;
                  state_r <= ST_OST; // [RULE2]
               end else begin
                  state_r <= ST_HOLD;
               end
            end
            ST_PWRT: begin
               if (cnt_r == {CNT_W{1'b0}}) begin
                  if (is_xtal(osc_mode_i)) begin
                     cnt_r <= OST_LD;
                     state_r <= ST_OST; // [RULE2]
                  end else begin
                     state_r <= ST_HOLD;
                  end
               end else begin
                  cnt_r <= cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
               end
            end
            ST_OST: begin
               if (cnt_r == {CNT_W{1'b0}}) begin
                  state_r <= from_wake_r ? ST_WAKE : ST_HOLD;
               end else begin
                  cnt_r <= cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
               end
            end
            ST_HOLD: begin
               // delays may expire while the pin is still low
               core_hold_o <= 1'b1;
               if (external_reset_pin_s2_r) begin
                  pc_load_o <= 1'b1;
                  pc_value_o <= `RCI_PC_RESET; // [RULE4]
                  core_hold_o <= 1'b0;
                  state_r <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (return_from_interrupt_i) begin
                  interrupt_control_r[`RCI_B_GIE] <= 1'b1; // [RULE10]
               end
               if (sleep_exec_i) begin
                  pd_r <= 1'b0; // [RULE16]
                  to_r <= 1'b1; // [RULE16]
                  lat_act_r <= 1'b0;
                  core_hold_o <= 1'b1;
                  state_r <= ST_SLEEP;
               end else if (!(global_irq_enable & irq_any)) begin
                  // request withdrawn, drop the pipeline
                  lat_act_r <= 1'b0;
               end else if (bnd) begin
                  // sampled on instruction boundaries only, so the
                  // length of the running instruction does not matter
                  if (!lat_act_r) begin
                     lat_act_r <= 1'b1;
                     lat_r <= `RCI_IRQ_LAT; // [RULE15]
                  end else if (lat_r == 2'h1) begin
                     lat_act_r <= 1'b0;
                     pc_load_o <= 1'b1;
                     pc_value_o <= `RCI_PC_VECTOR; // [RULE11] [RULE8]
                     stack_push_o <= 1'b1; // [RULE11]
                     interrupt_control_r[`RCI_B_GIE] <= 1'b0; // [RULE11]
                  end else begin
                     lat_r <= lat_r - 2'h1;
                  end
               end
               if (ev_wdt) begin
                  to_r <= 1'b0; // [RULE3]
               end
            end
            ST_SLEEP: begin
               core_hold_o <= 1'b1;
               if (wdt_timeout_i | irq_any) begin
                  if (wdt_timeout_i) begin
                     to_r <= 1'b0; // [RULE3]
                     wake_irq_r <= 1'b0;
                  end else begin
                     to_r <= 1'b1; // [RULE3]
                     wake_irq_r <= global_irq_enable;
                  end
                  pd_r <= 1'b0; // [RULE3]
                  if (conv_done_i) begin
                     conv_r[`RCI_B_CRUN] <= 1'b0; // [RULE5]
                  end
                  if (is_xtal(osc_mode_i)) begin
                     cnt_r <= OST_LD; // [RULE2]
                     from_wake_r <= 1'b1;
                     state_r <= ST_OST;
                  end else begin
                     state_r <= ST_WAKE;
                  end
               end
            end
            ST_WAKE: begin
               // continue at the next address unless vectored
               core_hold_o <= 1'b0;
               from_wake_r <= 1'b0;
               resume_o <= 1'b1;
               if (wake_irq_r) begin
                  pc_load_o <= 1'b1;
                  pc_value_o <= `RCI_PC_VECTOR; // [RULE4]
                  stack_push_o <= 1'b1; // [RULE11]
                  interrupt_control_r[`RCI_B_GIE] <= 1'b0; // [RULE11]
               end
               state_r <= ST_RUN;
            end
            default: begin
               state_r <= ST_POR;
            end
         endcase
         // pin and watchdog resets override state, interrupt (all but the port change flag), converter and option settings above;
         // power-on flag is deliberately left alone here
         if (soft_rst) begin
            if (ev_ext & in_slp) begin
               to_r <= 1'b1; // [RULE3]
               pd_r <= 1'b0; // [RULE3]
            end
            interrupt_control_r <= {7'h00, interrupt_control_r[`RCI_B_PORT_CHANGE_FLAG]}; // [RULE9]
            converter_done_flag_r <= 1'b0;
            adie_r <= 1'b0;
            conv_r <= 8'h00;
            opt_r <= `RCI_RST_OPTION;
            lat_act_r <= 1'b0;
            pc_load_o <= 1'b0;
            stack_push_o <= 1'b0;
            core_hold_o <= 1'b1;
            state_r <= ST_HOLD; // [RULE1]
         end
      end
   end

   // read data appear the cycle after the strobe
   always @(posedge core_clk_i) begin
      if (!rstn_i) begin
         rdata_o <= 8'h00;
      end else if (rd_i) begin
         case (addr_i)
            `RCI_A_STATUS: rdata_o <= {3'h0, to_r, pd_r, 3'h0};
            `RCI_A_POWER_CONTROL_STATUS: rdata_o <= {6'h00, por_flag_r, 1'b0};
            `RCI_A_INTERRUPT_CONTROL: rdata_o <= interrupt_control_r;
            `RCI_A_PIR: rdata_o <= {1'b0, converter_done_flag_r, 6'h00};
            `RCI_A_PIE: rdata_o <= {1'b0, adie_r, 6'h00};
            `RCI_A_CONV: rdata_o <= conv_r;
            `RCI_A_OPTION: rdata_o <= opt_r;
            `RCI_A_EVSTS: rdata_o <= {4'h0, evs_r};
            `RCI_A_EVMSK: rdata_o <= {4'h0, evm_r};
            default: rdata_o <= 8'h00;
         endcase
      end else begin
         rdata_o <= 8'h00;
      end
   end

endmodule

// ---- tb/rci_core_mdl.sv ----
// event source and core instruction model for the reset cause unit bench
`timescale 1ns/1ps
module rci_core_mdl (
   input wire [5:0] req_i,
   output wire timer_overflow_o,
   output wire port_change_o,
   output wire conv_done_o,
   output wire wdt_timeout_o,
   output wire sleep_exec_o,
   output wire ret_o
);
   // one-cycle pulses; the bench launches them right after an edge
   assign {ret_o, sleep_exec_o, wdt_timeout_o} = req_i[5:3];
   // three of the four documented interrupt sources; the bench drives the pin source directly
   assign {conv_done_o, port_change_o, timer_overflow_o} = req_i[2:0];
endmodule

// ---- tb/rci_top_properties.sv ----
// port level assertions for the reset cause and interrupt unit
`timescale 1ns/1ps
module rci_top_props (
   input wire core_clk_i,
   input wire rstn_i,
   input wire external_reset_pin_n_i,
   input wire wdt_timeout_i,
   input wire sleep_exec_i,
   input wire rd_i,
   input wire [7:0] rdata_o,
   input wire pc_load_o,
   input wire [12:0] pc_value_o,
   input wire stack_push_o,
   input wire core_hold_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rstn_i);
   // reset itself must hold the core and load nothing
   a_reset_holds_core: assert property (disable iff (1'b0)
      !rstn_i |=> core_hold_o && !pc_load_o) else $error("core not held in reset");
   a_reset_pc_zero: assert property (pc_load_o && !stack_push_o |->
      pc_value_o == 13'h0000) else $error("reset load not zero");
   a_load_runs_core: assert property (pc_load_o && !stack_push_o |=> !core_hold_o)
      else $error("core still held after load");
   a_push_vector: assert property (stack_push_o |-> pc_load_o &&
      pc_value_o == 13'h0004) else $error("push without vector load");
   // the take clears the global enable, so no second take can follow closely
   a_push_spacing: assert property (stack_push_o |=> !stack_push_o [*8])
      else $error("second take too soon");
   a_wdt_resets: assert property (wdt_timeout_i && !core_hold_o |=>
      ##[0:2] core_hold_o) else $error("watchdog did not reset");
   a_pin_resets: assert property (!external_reset_pin_n_i [*4] |=> core_hold_o)
      else $error("reset pin ignored");
   a_sleep_holds: assert property (sleep_exec_i && !core_hold_o |=>
      ##[0:1] core_hold_o) else $error("sleep did not hold core");
   a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
      else $error("read data outside read slot");
endmodule
bind rci_top rci_top_props rci_top_props_i (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
   .external_reset_pin_n_i(external_reset_pin_n_i), .wdt_timeout_i(wdt_timeout_i),
   .sleep_exec_i(sleep_exec_i), .rd_i(rd_i), .rdata_o(rdata_o), .pc_load_o(pc_load_o),
   .pc_value_o(pc_value_o), .stack_push_o(stack_push_o), .core_hold_o(core_hold_o));

// ---- tb/tb.sv ----
// self-checking bench for the reset cause and interrupt unit
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin err_total++; \
   $display("unexpected %s exp %h got %h", n, e, s); end end
module tb;
   logic core_clk_i = 0, rstn_i = 0, pin_n = 1, irq_pin = 1, wr_i = 0, rd_i = 0;
   logic [7:0] addr_i = 0, wdata_i = 0;
   logic [5:0] req = 0;
   logic [7:0] rdata_o;
   logic [12:0] pc_value_o;
   logic pc_load_o, stack_push_o, resume_o, core_hold_o, irq_o;
   wire t_ov, p_ch, c_dn, wdt, slp, rfi;
   int err_total = 0, comparisons = 0, cycles = 0;
   always #12.5 core_clk_i = ~core_clk_i;
   rci_core_mdl rci_core_mdl_i (.req_i(req), .timer_overflow_o(t_ov), .port_change_o(p_ch),
      .conv_done_o(c_dn), .wdt_timeout_o(wdt), .sleep_exec_o(slp), .ret_o(rfi));
   // short timer counts keep the run brief; checks scale from them
   rci_top #(.PWRT_CYC(20), .OST_CYC(8)) rci_top_i (.core_clk_i(core_clk_i),
      .rstn_i(rstn_i), .external_reset_pin_n_i(pin_n), .external_irq_pin_i(irq_pin),
      .power_up_timer_enable_n_i(1'b0), .osc_mode_i(3'h1), .wdt_timeout_i(wdt),
      .sleep_exec_i(slp), .return_from_interrupt_i(rfi), .timer_overflow_i(t_ov),
      .port_change_i(p_ch), .conv_done_i(c_dn), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pc_load_o(pc_load_o),
      .pc_value_o(pc_value_o), .stack_push_o(stack_push_o), .resume_o(resume_o),
      .core_hold_o(core_hold_o), .irq_o(irq_o));
   task automatic end_sim;
      if (err_total == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // hang guard, far above the expected few hundred cycles
   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         end_sim;
      end
   end
   task automatic cyc(input int k);
      repeat (k) @(posedge core_clk_i);
      #1;
   endtask
   task automatic wr8(input logic [7:0] a, d);
      @(posedge core_clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1;
      @(posedge core_clk_i);
      wr_i <= 0;
   endtask
   task automatic rd8(input logic [7:0] a, m, e);
      @(posedge core_clk_i);
      addr_i <= a;
      rd_i <= 1;
      @(posedge core_clk_i);
      rd_i <= 0;
      #1 `CHK("rdata", e, rdata_o & m)
   endtask
   task automatic ev(input logic [5:0] k);
      @(posedge core_clk_i);
      req <= k;
      @(posedge core_clk_i);
      req <= 0;
   endtask
   task automatic pins(input logic rp, ip);
      @(posedge core_clk_i);
      pin_n <= rp;
      irq_pin <= ip;
      cyc(6);
   endtask
   // bounded wait for a load (sel 0) or a resume (sel 1)
   task automatic wsig(input int sel, lim, output int n);
      n = 0;
      do begin
         cyc(1);
         n++;
      end while (((sel ? resume_o : pc_load_o) !== 1'b1) && n < lim);
      `CHK("wait", 1'b1, n < lim)
   endtask
   initial begin
      int n;
      logic [7:0] v;
      v = $urandom(2945);
      cyc(2);
      rstn_i <= 1;
      wsig(0, 200, n);
      `CHK("boot", 1'b1, n >= 28)
      rd8(8'h03, 8'h18, 8'h18);
      rd8(8'h8e, 8'h02, 8'h00);
      rd8(8'h0b, 8'hff, 8'h00);
      wr8(8'h8e, 8'h02);
      // power-on event: raise, mask, unmask, clear
      wr8(8'h91, 8'h01);
      cyc(2);
      `CHK("irq", 1'b1, irq_o)
      wr8(8'h91, 8'h00);
      cyc(2);
      `CHK("irq", 1'b0, irq_o)
      wr8(8'h91, 8'h01);
      wr8(8'h90, 8'h01);
      cyc(2);
      `CHK("irq", 1'b0, irq_o)
      ev(6'h07);
      rd8(8'h0b, 8'h07, 8'h05);
      rd8(8'h0c, 8'h40, 8'h40);
      // clearing write meets a timer event in the same cycle
      @(posedge core_clk_i);
      addr_i <= 8'h0b;
      wdata_i <= 8'h00;
      wr_i <= 1;
      req <= 6'h01;
      @(posedge core_clk_i);
      wr_i <= 0;
      req <= 0;
      rd8(8'h0b, 8'h07, 8'h04);
      wr8(8'h0b, 8'h00);
      rd8(8'h0b, 8'h07, 8'h00);
      // edge select with random other option bits
      v = $urandom;
      wr8(8'h81, v | 8'h40);
      rd8(8'h81, 8'hff, v | 8'h40);
      pins(1, 0);
      rd8(8'h0b, 8'h02, 8'h00);
      pins(1, 1);
      rd8(8'h0b, 8'h02, 8'h02);
      wr8(8'h81, v & 8'hbf);
      wr8(8'h0b, 8'h00);
      pins(1, 0);
      rd8(8'h0b, 8'h02, 8'h02);
      wr8(8'h0b, 8'ha0);
      ev(6'h01);
      wsig(0, 40, n);
      // three to four instruction cycles of four clocks each
      `CHK("latency", 1'b1, n >= 12 && n <= 16)
      `CHK("push", 1'b1, stack_push_o)
      `CHK("pc", 13'h0004, pc_value_o)
      rd8(8'h0b, 8'h84, 8'h04);
      wr8(8'h0b, 8'h20);
      ev(6'h20);
      rd8(8'h0b, 8'h84, 8'h80);
      ev(6'h08);
      wsig(0, 200, n);
      rd8(8'h03, 8'h18, 8'h08);
      rd8(8'h8e, 8'h02, 8'h02);
      rd8(8'h0b, 8'h80, 8'h00);
      rd8(8'h90, 8'h04, 8'h04);
      pins(0, 0);
      // release the pin and watch for the load right away
      @(posedge core_clk_i);
      pin_n <= 1;
      wsig(0, 200, n);
      rd8(8'h03, 8'h18, 8'h08);
      ev(6'h10);
      rd8(8'h03, 8'h18, 8'h10);
      ev(6'h08);
      wsig(1, 100, n);
      `CHK("ost", 1'b1, n >= 8)
      rd8(8'h03, 8'h18, 8'h00);
      // converter wake with global enable set must vector
      wr8(8'h0c, 8'h00);
      wr8(8'h1f, 8'h08);
      wr8(8'h8c, 8'h40);
      wr8(8'h0b, 8'hc0);
      ev(6'h10);
      ev(6'h04);
      wsig(1, 100, n);
      `CHK("pc", 13'h0004, pc_load_o ? pc_value_o : 13'h1fff)
      rd8(8'h0c, 8'h40, 8'h40);
      rd8(8'h1f, 8'h08, 8'h00);
      rd8(8'h03, 8'h18, 8'h10);
      // drop the converter flag so the sleep is not woken at once
      wr8(8'h0c, 8'h00);
      ev(6'h10);
      pins(0, 0);
      @(posedge core_clk_i);
      pin_n <= 1;
      wsig(0, 200, n);
      rd8(8'h03, 8'h18, 8'h10);
      end_sim;
   end
endmodule
